// File: rtl/scp_pkg.sv
package scp_pkg;
    // Frame geometry: bytes of 8 bits, MSB first, any number per frame
    localparam int SCP_WORD_W = 8;
    localparam logic [2:0] SCP_BIT_LAST = 3'h7;
    localparam logic [2:0] SCP_BIT_RST = 3'h0;
    localparam logic [7:0] SCP_BYTE_RST = 8'h00;
    // Synchroniser reset levels match the idle level of each pin
    localparam logic [2:0] SCP_SYNC_LO = 3'h0;
    localparam logic [2:0] SCP_SYNC_HI = 3'h7;
    // Identity byte returned on the first byte; arbitrary value
    localparam logic [7:0] SCP_ID_BYTE = 8'h5A;
    // Link timing
    localparam int SCP_CLK_NS = 40;
    localparam int SCP_SYNC_LEN = 3;

    typedef enum logic [0:0] {
        SCP_IDLE = 1'b0,
        SCP_SHIFT = 1'b1
    } scp_state_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
        logic user_pin_one;
    } scp_pins_t;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } scp_word_t;
endpackage

// File: rtl/scp_serial_port.sv
`timescale 1ns/1ps
module scp_serial_port
    import scp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Link pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_n_o,
    // Mode and user pin
    input wire logic pin_follow_mode_i,
    input wire logic user_pin_one_i,
    // Device side data
    input wire logic [7:0] tx_data_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage synchronisers; only stages 2 and 3 are read
    wire scp_pins_t pins_in;
    assign pins_in = '{sclk: sclk_i, cs_n: cs_n_i, din: din_i, user_pin_one: user_pin_one_i};
    logic [2:0] sclk_s_r, cs_s_r, din_s_r, upin_s_r;
    logic sclk_q_r, cs_q_r, din_q_r, upin_q_r;

    // Select resets high so that leaving reset with select high never looks like a new frame
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_s_r <= SCP_SYNC_LO;
            cs_s_r <= SCP_SYNC_HI;
            din_s_r <= SCP_SYNC_LO;
            upin_s_r <= SCP_SYNC_LO;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], pins_in.sclk};
            cs_s_r <= {cs_s_r[1:0], pins_in.cs_n};
            din_s_r <= {din_s_r[1:0], pins_in.din};
            upin_s_r <= {upin_s_r[1:0], pins_in.user_pin_one};
        end
    end

    // A level counts once stages 2 and 3 agree
    function automatic logic agreed(input logic [2:0] s, input logic held);
        return (s[2] == s[1]) ? s[2] : held;
    endfunction

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q_r <= 1'b0;
            cs_q_r <= 1'b1;
            din_q_r <= 1'b0;
            upin_q_r <= 1'b0;
        end else begin
            sclk_q_r <= agreed(sclk_s_r, sclk_q_r);
            cs_q_r <= agreed(cs_s_r, cs_q_r);
            din_q_r <= agreed(din_s_r, din_q_r);
            upin_q_r <= agreed(upin_s_r, upin_q_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge decode; sclk edges are only sampled at 25 MHz, so a host clock
    // much faster than a few MHz is not supported
    scp_state_t state_r, state_nxt;
    wire logic sclk_new = agreed(sclk_s_r, sclk_q_r);
    wire logic cs_new = agreed(cs_s_r, cs_q_r);
    wire logic in_frame = (state_r == SCP_SHIFT);
    // Incoming select must be low too, so an edge racing a select rise is dropped
    wire logic selected = in_frame & ~cs_new;
    wire logic sclk_rise = sclk_new & ~sclk_q_r & selected;
    wire logic sclk_fall = ~sclk_new & sclk_q_r & selected;
    wire logic cs_rise = cs_new & ~cs_q_r;
    wire logic cs_fall = ~cs_new & cs_q_r;
    wire logic din_now = agreed(din_s_r, din_q_r);

    ////////////////////////////////////////////////////////////////////////////
    // Shift engine
    logic [2:0] bit_r;
    logic [7:0] rx_sh_r, tx_sh_r;
    scp_word_t rx_word_r;
    logic dout_r, oe_n_r;

    wire logic last_bit = (bit_r == SCP_BIT_LAST);
    wire logic [7:0] rx_next = {rx_sh_r[6:0], din_now};
    // A select rise in the same cycle drops the byte
    wire logic byte_done = sclk_rise & last_bit & ~cs_rise;
    wire logic dout_nxt = pin_follow_mode_i ? upin_q_r : tx_sh_r[7];

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SCP_IDLE: if (cs_fall) state_nxt = SCP_SHIFT;
            SCP_SHIFT: if (cs_rise) state_nxt = SCP_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= SCP_IDLE;
            bit_r <= SCP_BIT_RST;
            rx_sh_r <= SCP_BYTE_RST;
        end else begin
            state_r <= state_nxt;
            if (cs_rise || cs_fall) begin
                bit_r <= SCP_BIT_RST;
                rx_sh_r <= SCP_BYTE_RST;
            end else if (sclk_rise) begin
                bit_r <= bit_r + 3'h1;
                rx_sh_r <= rx_next;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_word_r <= '{data: SCP_BYTE_RST, valid: 1'b0};
        end else begin
            rx_word_r.valid <= byte_done;
            if (byte_done) begin
                rx_word_r.data <= rx_next;
            end
        end
    end

    // Load the next byte on the sclk fall after a byte's last rise; first byte is the identity
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_sh_r <= SCP_ID_BYTE;
        end else if (cs_fall || cs_rise) begin
            tx_sh_r <= SCP_ID_BYTE;
        end else if (sclk_fall) begin
            tx_sh_r <= (bit_r == SCP_BIT_RST) ? tx_data_i : {tx_sh_r[6:0], 1'b0};
        end
    end

    // Output register; enable low while driving
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dout_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            oe_n_r <= cs_new;
            dout_r <= dout_nxt;
        end
    end

    assign dout_o = dout_r;
    assign dout_oe_n_o = oe_n_r;
    assign rx_data_o = rx_word_r.data;
    assign rx_valid_o = rx_word_r.valid;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_desel;
        cs_q_r ##1 cs_q_r;
    endsequence

    sequence s_sel;
        !cs_q_r ##1 !cs_q_r;
    endsequence

    // Valid is a single-cycle pulse
    sequence s_pulse;
        rx_valid_o ##1 !rx_valid_o;
    endsequence

    // After a select edge the port stands at the start of a byte
    sequence s_fresh;
        bit_r == SCP_BIT_RST && tx_sh_r == SCP_ID_BYTE && !rx_valid_o;
    endsequence

    chk_oe_follows_cs: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_desel |-> dout_oe_n_o)
        else $error("output driven while deselected");
    chk_oe_drives_sel: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_sel |-> !dout_oe_n_o)
        else $error("output released while selected");
    chk_follow_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        pin_follow_mode_i |=> dout_o == $past(upin_q_r))
        else $error("output not following pin");
    chk_dout_from_shift: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !pin_follow_mode_i |=> dout_o == $past(tx_sh_r[7]))
        else $error("output not from shifter");
    chk_cnt_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cs_rise |=> bit_r == SCP_BIT_RST)
        else $error("counter not cleared");
    chk_frame_fresh: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cs_rise || cs_fall |=> s_fresh)
        else $error("frame not restarted");
    chk_cs_rise_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cs_rise |=> !in_frame)
        else $error("frame kept after deselect");
    chk_no_shift_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_desel |=> $stable(bit_r))
        else $error("shift while deselected");
    chk_no_rx_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !in_frame |=> !rx_valid_o)
        else $error("byte taken while deselected");
    chk_rise_counts: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sclk_rise && !cs_rise |=> bit_r == $past(bit_r) + 3'h1)
        else $error("rise not counted");
    chk_din_capture: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sclk_rise |=> rx_sh_r[0] == $past(din_now))
        else $error("input bit not taken");
    chk_rx_capture: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        byte_done |=> s_pulse)
        else $error("byte lost");
    chk_rx_byte: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        byte_done |=> rx_data_o == $past(rx_next))
        else $error("wrong byte handed over");
    chk_fall_shift: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sclk_fall && bit_r != SCP_BIT_RST && !cs_rise |=> tx_sh_r == {$past(tx_sh_r[6:0]), 1'b0})
        else $error("output bit not advanced");
    chk_byte_reload: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sclk_fall && bit_r == SCP_BIT_RST |=> tx_sh_r == $past(tx_data_i))
        else $error("next byte not loaded");
    chk_hold_no_fall: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !sclk_fall && !cs_rise && !cs_fall |=> $stable(tx_sh_r))
        else $error("output moved off edge");

endmodule

// File: verif/scp_host_model.sv
`timescale 1ns/1ps
// Host acting as bus master; serial clock idles low and can also be pulsed while deselected, between frames
module scp_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    input wire logic dout_i,
    input wire logic dout_oe_n_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end
    // Select stays put for the whole frame; released data line flips so stale values never match
    task automatic sel(input logic s);
        cs_n_o = ~s;
        if (!s) din_o = ~din_o;
        #320;
    endtask
    // Data set while clock low, held across the rise; output sampled late to cover sync lag
    task automatic shift_bit(input logic b, output logic q);
        din_o = b;
        #160 sclk_o = 1'b1;
        #120 q = dout_oe_n_i ? 1'bx : dout_i;
        #40 sclk_o = 1'b0;
    endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("wrong value %0t: %h", $time, a); end end
module tb_top;
    import scp_pkg::*;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, mode = 1'b0, upin = 1'b0, q;
    logic [7:0] tx_data = 8'h00, r;
    wire logic sclk, cs_n, din, dout, oe_n, rx_valid;
    wire logic [7:0] rx_data;
    int errors = 0, cmp_count = 0, pulses = 0, p;
    always #20 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (rx_valid === 1'b1) pulses++;
    scp_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout), .dout_oe_n_i(oe_n));
    scp_serial_port i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
        .dout_o(dout), .dout_oe_n_o(oe_n), .pin_follow_mode_i(mode), .user_pin_one_i(upin),
        .tx_data_i(tx_data), .rx_data_o(rx_data), .rx_valid_o(rx_valid));
    ////////////////////////////////////////////////////////////////
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) i_host.shift_bit(tx[i], rx[i]);
    endtask
    task automatic t_two_bytes;
        tx_data = 8'hC3;
        upin = 1'b1;
        p = pulses;
        i_host.sel(1'b1);
        `CHK(oe_n, 1'b0)
        xbyte(8'hA5, r);
        `CHK(r, SCP_ID_BYTE)
        xbyte(8'h3C, r);
        `CHK(r, 8'hC3)
        i_host.sel(1'b0);
        `CHK(rx_data, 8'h3C)
        `CHK(pulses - p, 2)
        `CHK(oe_n, 1'b1)
    endtask
    task automatic t_cs_high;
        p = pulses;
        for (int i = 0; i < 8; i++) begin
            i_host.shift_bit(1'b1, q);
            `CHK(oe_n, 1'b1)
        end
        `CHK(pulses - p, 0)
    endtask
    // Dropped bits must not shift the next frame
    task automatic t_partial;
        i_host.sel(1'b1);
        for (int i = 0; i < 5; i++) i_host.shift_bit(1'b1, q);
        i_host.sel(1'b0);
        p = pulses;
        i_host.sel(1'b1);
        tx_data = 8'h3C;
        xbyte(8'h81, r);
        `CHK(r, SCP_ID_BYTE)
        `CHK(rx_data, 8'h81)
        xbyte(8'h7E, r);
        `CHK(r, 8'h3C)
        i_host.sel(1'b0);
        `CHK(rx_data, 8'h7E)
        `CHK(pulses - p, 2)
    endtask
    // Reset in mid-frame must leave the port idle and ready for a clean frame
    task automatic t_reset_mid;
        i_host.sel(1'b1);
        for (int i = 0; i < 3; i++) i_host.shift_bit(1'b0, q);
        rst_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        `CHK(oe_n, 1'b1)
        `CHK(rx_data, SCP_BYTE_RST)
        i_host.sel(1'b0);
        rst_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        i_host.sel(1'b1);
        xbyte(8'h55, r);
        `CHK(r, SCP_ID_BYTE)
        i_host.sel(1'b0);
        `CHK(rx_data, 8'h55)
    endtask
    task automatic t_follow;
        mode = 1'b1;
        i_host.sel(1'b1);
        for (int v = 0; v < 3; v++) begin
            upin = v[0] ^ 1'b1;
            for (int k = 0; k < 8 && dout !== upin; k++) @(negedge ref_clk_i);
            `CHK(dout, upin)
        end
        i_host.sel(1'b0);
        `CHK(oe_n, 1'b1)
        mode = 1'b0;
    endtask
    task automatic close_out;
        if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge ref_clk_i);
        `CHK(oe_n, 1'b1)
        `CHK(rx_data, SCP_BYTE_RST)
        rst_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        t_two_bytes();
        t_cs_high();
        t_partial();
        t_reset_mid();
        t_follow();
        close_out();
    end
endmodule
